// file: sfps_pkg.sv
// package: constants for the flash power-up sequencer and serial front end
package sfps_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // power-up delay before program/erase, in microseconds
  localparam int unsigned PROG_WAIT_US = 3000;
  // read wait after supply, in microseconds
  localparam int unsigned READ_WAIT_US = 70;
  localparam int unsigned PROG_WAIT_CYC = (PROG_WAIT_US * 1000 * 1000) / CLK_PERIOD_PS;
  localparam int unsigned READ_WAIT_CYC = (READ_WAIT_US * 1000 * 1000 + CLK_PERIOD_PS - 1)
                                          / CLK_PERIOD_PS;
  localparam logic [7:0] OP_BUF1_READ = 8'hd4;
  localparam logic [7:0] OP_BUF2_READ = 8'hd6;
  localparam logic [7:0] OP_STATUS_READ = 8'hd7;
  localparam int unsigned OPCODE_BITS = 8;
  localparam int unsigned ADDR_BITS = 24;
  localparam int unsigned BYTE_ADDR_BITS = 9;
  localparam int unsigned BUF_BYTES = 512;
  localparam logic [5:0] LAST_ADDR_BIT = 6'h17;
  localparam logic [5:0] LAST_OP_BIT = 6'h07;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [7:0] STATUS_READY = 8'h80;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  typedef enum logic [1:0] {SFPS_POR, SFPS_STANDBY, SFPS_ACTIVE} sfps_pwr_e;
  typedef enum logic [1:0] {SFPS_IDLE, SFPS_OPCODE, SFPS_ADDR, SFPS_DATA} sfps_cmd_e;
endpackage

// file: sfps_buf_mem.sv
// file: small buffer memory with registered read data
`timescale 1ns/1ps
module sfps_buf_mem #(
  parameter int unsigned DEPTH = 512,
  parameter int unsigned AW = 9
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: sfps_top.sv
// file: power-up sequencer and serial command front end of the flash slave
`timescale 1ns/1ps
// Notes on behaviour
// - data output stays undriven after power-up or reset until an instruction drives it.
// - decoding starts only after a falling edge on select_n following reset.
// - every select_n fall after por release samples clock idle level: low gives mode 0, high mode 3.
// - while power-on reset is held, every command is ignored.
// - after the power-up delay, standby if select_n high, else active.
// - buffer reads take opcode, 15 dummy bits, 9 byte address bits.
// - status read takes the opcode alone, no address or dummy bits.
module sfps_top
  import sfps_pkg::*;
#(
  parameter int unsigned PUW_CYC = PROG_WAIT_CYC,
  parameter int unsigned VCSL_CYC = READ_WAIT_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic buf_we,
  input wire logic buf_sel,
  input wire logic [8:0] buf_waddr,
  input wire logic [7:0] buf_wdata,
  output logic sdo,
  output logic sdo_oe,
  output logic mode3,
  output logic [1:0] pwr_state,
  output logic prog_allowed,
  output logic read_allowed
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change taken when stages two and three agree
  logic [2:0] cs_sync;
  logic [2:0] ck_sync;
  logic [2:0] di_sync;
  logic cs_q;
  logic ck_q;
  logic ck_prev;
  logic di_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_sync <= 3'h7;
      ck_sync <= 3'h0;
      di_sync <= 3'h0;
    end else begin
      cs_sync <= {cs_sync[1:0], select_n};
      ck_sync <= {ck_sync[1:0], sclk};
      di_sync <= {di_sync[1:0], sdi};
    end
  end

  wire cs_agree = cs_sync[1] == cs_sync[2];
  wire ck_agree = ck_sync[1] == ck_sync[2];
  wire di_agree = di_sync[1] == di_sync[2];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_q <= 1'b1;
      ck_q <= 1'b0;
      ck_prev <= 1'b0;
      di_q <= 1'b0;
    end else begin
      if (cs_agree) begin
        cs_q <= cs_sync[2];
      end
      if (ck_agree) begin
        ck_q <= ck_sync[2];
      end
      ck_prev <= ck_q;
      if (di_agree) begin
        di_q <= di_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on reset: por_n caught by two clocked stages
  logic por_q;
  logic por_s;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      por_s <= 1'b0;
      por_q <= 1'b0;
    end else begin
      por_s <= por_n;
      por_q <= por_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up delay counter and power state
  logic [31:0] up_cnt;
  sfps_pwr_e pwr;
  wire puw_done = up_cnt >= 32'(PUW_CYC);
  wire vcsl_done = up_cnt >= 32'(VCSL_CYC);
  wire cs_fall = cs_q && cs_agree && !cs_sync[2];
  wire ck_rise = ck_q && !ck_prev;
  wire ck_fall = !ck_q && ck_prev;

  sfps_pwr_e next_pwr;
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      SFPS_POR: begin
        if (puw_done) begin
          next_pwr = cs_q ? SFPS_STANDBY : SFPS_ACTIVE;
        end
      end
      SFPS_STANDBY: begin
        if (!cs_q) begin
          next_pwr = SFPS_ACTIVE;
        end
      end
      SFPS_ACTIVE: begin
        if (cs_q) begin
          next_pwr = SFPS_STANDBY;
        end
      end
      default: next_pwr = SFPS_POR;
    endcase
    if (!por_q) begin
      next_pwr = SFPS_POR;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      up_cnt <= 32'h0;
      pwr <= SFPS_POR;
      prog_allowed <= 1'b0;
      read_allowed <= 1'b0;
      pwr_state <= 2'h0;
    end else begin
      if (!por_q) begin
        up_cnt <= 32'h0;
      end else if (!puw_done) begin
        up_cnt <= up_cnt + 32'h1;
      end
      pwr <= next_pwr;
      pwr_state <= next_pwr;
      prog_allowed <= por_q && puw_done;
      read_allowed <= por_q && vcsl_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command framing
  sfps_cmd_e cmd;
  logic armed;
  logic [5:0] bit_cnt;
  logic [7:0] opcode;
  logic [8:0] byte_addr;
  logic [7:0] out_byte;
  logic [2:0] out_bit;
  logic load_pend;
  logic [7:0] rd0;
  logic [7:0] rd1;

  // a command runs only after por release and a fresh select_n fall
  wire live = por_q && armed && !cs_q;
  wire op_done = cmd == SFPS_OPCODE && ck_rise && bit_cnt == LAST_OP_BIT;
  wire [7:0] op_word = {opcode[6:0], di_q};
  wire is_buf = op_word == OP_BUF1_READ || op_word == OP_BUF2_READ;
  wire is_stat = op_word == OP_STATUS_READ;
  wire addr_done = cmd == SFPS_ADDR && ck_rise && bit_cnt == LAST_ADDR_BIT;
  wire [8:0] next_addr = {byte_addr[7:0], di_q};
  wire [7:0] status_word = puw_done ? STATUS_READY : STATUS_RESET;
  wire [7:0] buf_rd = opcode == OP_BUF2_READ ? rd1 : rd0;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode3 <= 1'b0;
      armed <= 1'b0;
    end else if (!por_q) begin
      armed <= 1'b0;
    end else if (cs_fall) begin
      mode3 <= ck_q;
      armed <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd <= SFPS_IDLE;
      bit_cnt <= 6'h0;
      opcode <= 8'h0;
      byte_addr <= 9'h0;
      load_pend <= 1'b0;
    end else if (!live) begin
      cmd <= cs_fall && por_q ? SFPS_OPCODE : SFPS_IDLE;
      bit_cnt <= 6'h0;
      load_pend <= 1'b0;
    end else begin
      load_pend <= 1'b0;
      case (cmd)
        SFPS_OPCODE: begin
          if (ck_rise) begin
            opcode <= op_word;
            bit_cnt <= bit_cnt + 6'h1;
          end
          if (op_done) begin
            bit_cnt <= 6'h0;
            cmd <= is_buf ? SFPS_ADDR : (is_stat ? SFPS_DATA : SFPS_IDLE);
            load_pend <= is_stat;
          end
        end
        SFPS_ADDR: begin
          if (ck_rise) begin
            byte_addr <= next_addr;
            bit_cnt <= bit_cnt + 6'h1;
          end
          if (addr_done) begin
            cmd <= SFPS_DATA;
            load_pend <= 1'b1;
          end
        end
        SFPS_DATA: begin
          if (ck_fall && out_bit == LAST_DATA_BIT && opcode != OP_STATUS_READ) begin
            byte_addr <= byte_addr + 9'h1;
            load_pend <= 1'b1;
          end
        end
        default: cmd <= SFPS_IDLE;
      endcase
    end
  end

  // memory read lags a cycle, so the byte loads one cycle after load_pend
  logic load_now;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      load_now <= 1'b0;
      out_byte <= 8'h0;
      out_bit <= 3'h0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      load_now <= load_pend;
      if (load_now) begin
        out_byte <= opcode == OP_STATUS_READ ? status_word : buf_rd;
        out_bit <= 3'h0;
      end else if (cmd == SFPS_DATA && ck_fall) begin
        out_byte <= {out_byte[6:0], out_byte[7]};
        out_bit <= out_bit + 3'h1;
      end
      sdo <= out_byte[7];
      sdo_oe <= live && cmd == SFPS_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the two data buffers
  sfps_buf_mem #(.DEPTH(BUF_BYTES), .AW(BYTE_ADDR_BITS)) u_buf0 (
    .mclk(mclk),
    .we(buf_we && !buf_sel),
    .waddr(buf_waddr),
    .wdata(buf_wdata),
    .raddr(byte_addr),
    .rdata(rd0)
  );
  sfps_buf_mem #(.DEPTH(BUF_BYTES), .AW(BYTE_ADDR_BITS)) u_buf1 (
    .mclk(mclk),
    .we(buf_we && buf_sel),
    .waddr(buf_waddr),
    .wdata(buf_wdata),
    .raddr(byte_addr),
    .rdata(rd1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_sdo_quiet;
    @(posedge mclk) disable iff (!rstn) (cmd != SFPS_DATA) |=> !sdo_oe;
  endproperty
  a_sdo_quiet: assert property (p_sdo_quiet) else $error("sdo driven outside data");
  property p_mode_sample;
    @(posedge mclk) disable iff (!rstn) (por_q && cs_fall) |=> mode3 == $past(ck_q);
  endproperty
  a_mode_sample: assert property (p_mode_sample) else $error("mode not sampled");
  property p_por_quiet;
    @(posedge mclk) disable iff (!rstn) !por_q |=> cmd == SFPS_IDLE && !armed;
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("command during por");
  property p_arm;
    @(posedge mclk) disable iff (!rstn) (!armed && cmd == SFPS_IDLE) |=> cmd != SFPS_ADDR;
  endproperty
  a_arm: assert property (p_arm) else $error("decode without select fall");
  property p_pwr_exit;
    @(posedge mclk) disable iff (!rstn)
      (pwr == SFPS_POR && por_q && puw_done) |=> pwr == ($past(cs_q) ? SFPS_STANDBY : SFPS_ACTIVE);
  endproperty
  a_pwr_exit: assert property (p_pwr_exit) else $error("wrong state after delay");
  property p_prog_wait;
    @(posedge mclk) disable iff (!rstn) prog_allowed |-> up_cnt >= 32'(PUW_CYC);
  endproperty
  a_prog_wait: assert property (p_prog_wait) else $error("program allowed early");
  property p_read_wait;
    @(posedge mclk) disable iff (!rstn) read_allowed |-> up_cnt >= 32'(VCSL_CYC);
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read allowed early");
  property p_stat_direct;
    @(posedge mclk) disable iff (!rstn) (live && op_done && is_stat) |=> cmd == SFPS_DATA;
  endproperty
  a_stat_direct: assert property (p_stat_direct) else $error("status read not direct");
  property p_buf_addr;
    @(posedge mclk) disable iff (!rstn) (live && op_done && is_buf) |=> cmd == SFPS_ADDR;
  endproperty
  a_buf_addr: assert property (p_buf_addr) else $error("buffer read skipped address");
  c_mode3: cover property (@(posedge mclk) disable iff (!rstn) cs_fall && ck_q);
  c_status: cover property (@(posedge mclk) disable iff (!rstn) live && op_done && is_stat);
  c_bufread: cover property (@(posedge mclk) disable iff (!rstn) live && addr_done);
endmodule

// file: sfps_host.sv
// serial host model driving select, clock and data
`timescale 1ns/1ps
module sfps_host #(
  parameter int H = 10
) (
  input wire logic mclk,
  output logic select_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic oe_seen;
  initial begin
    select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    oe_seen = 1'b1;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // clock stands at this level outside frames
  task automatic idle(input logic lvl);
    @(negedge mclk);
    sclk = lvl;
  endtask
  task automatic sel(input logic v);
    @(negedge mclk);
    select_n = v;
    if (v) begin
      sdi = ~sdi;
    end
  endtask
  // msb first, data changes while clock low
  task automatic shift(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge mclk);
      sclk = 1'b0;
      sdi = v[i];
      gap(H);
      sclk = 1'b1;
      gap(H);
    end
  endtask
  // sample each bit just before the clock falls
  task automatic rd(input int n, output logic [15:0] v);
    oe_seen = 1'b1;
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        sclk = 1'b0;
        gap(H);
        sclk = 1'b1;
        gap(H);
      end
      // released line reads as the inverse of the stale bit
      v = {v[14:0], sdo_oe ? sdo : ~sdo};
      oe_seen = oe_seen & sdo_oe;
    end
  endtask
endmodule

// file: sfps_top_tb.sv
// self-checking bench for the power-up sequencer
`timescale 1ns/1ps
module sfps_top_tb;
  import sfps_pkg::*;
  localparam int PUW = 50;
  localparam int VCSL = 20;
  logic mclk;
  logic rstn;
  logic por_n;
  logic select_n;
  logic sclk;
  logic sdi;
  logic buf_we;
  logic buf_sel;
  logic [8:0] buf_waddr;
  logic [7:0] buf_wdata;
  logic sdo;
  logic sdo_oe;
  logic mode3;
  logic prog_allowed;
  logic read_allowed;
  logic [1:0] pwr_state;
  logic [15:0] got;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  sfps_top #(.PUW_CYC(PUW), .VCSL_CYC(VCSL)) dut (
    .mclk(mclk),
    .rstn(rstn),
    .por_n(por_n),
    .select_n(select_n),
    .sclk(sclk),
    .sdi(sdi),
    .buf_we(buf_we),
    .buf_sel(buf_sel),
    .buf_waddr(buf_waddr),
    .buf_wdata(buf_wdata),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .mode3(mode3),
    .pwr_state(pwr_state),
    .prog_allowed(prog_allowed),
    .read_allowed(read_allowed)
  );
  sfps_host host (
    .mclk(mclk),
    .select_n(select_n),
    .sclk(sclk),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe)
  );
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bwrite(input logic s, input logic [8:0] a, input logic [7:0] d);
    @(negedge mclk);
    buf_sel = s;
    buf_we = 1'b1;
    buf_waddr = a;
    buf_wdata = d;
    @(negedge mclk);
    buf_we = 1'b0;
  endtask
  // one framed command; na address bits, nb bits read back
  task automatic xfer(input logic m3, input logic [7:0] op, input int na,
                      input logic [23:0] a, input int nb);
    host.idle(m3);
    host.gap(6);
    host.sel(1'b0);
    host.gap(6);
    host.shift({op, a} >> (24 - na), 8 + na);
    host.rd(nb, got);
    chk("mode3", {15'h0000, m3}, {15'h0000, mode3});
    chk("oe data", 1'b1, host.oe_seen);
    host.sel(1'b1);
    host.gap(10);
    chk("oe idle", 1'b0, sdo_oe);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_por_ignore();
    host.idle(1'b0);
    host.sel(1'b0);
    host.shift({24'h000000, OP_STATUS_READ}, 8);
    host.gap(8);
    chk("oe por", 1'b0, sdo_oe);
    por_n = 1'b1;
    host.gap(8);
    host.shift({24'h000000, OP_STATUS_READ}, 8);
    host.gap(8);
    chk("oe no fall", 1'b0, sdo_oe);
    host.gap(PUW);
    chk("state active", SFPS_ACTIVE, pwr_state);
    host.sel(1'b1);
  endtask
  task automatic t_power_waits();
    @(negedge mclk);
    por_n = 1'b0;
    host.gap(4);
    chk("state por", SFPS_POR, pwr_state);
    chk("read in por", 1'b0, read_allowed);
    por_n = 1'b1;
    host.gap(12);
    chk("read early", 1'b0, read_allowed);
    host.gap(18);
    chk("read ok", 1'b1, read_allowed);
    chk("prog early", 1'b0, prog_allowed);
    host.gap(30);
    chk("prog ok", 1'b1, prog_allowed);
    chk("state standby", SFPS_STANDBY, pwr_state);
  endtask
  task automatic t_status();
    xfer(1'b0, OP_STATUS_READ, 0, 24'h000000, 16);
    chk("status m0", {STATUS_READY, STATUS_READY}, got);
    xfer(1'b1, OP_STATUS_READ, 0, 24'h000000, 8);
    chk("status m3", {8'h00, STATUS_READY}, got);
  endtask
  // an opcode outside the decoded set never drives the output
  task automatic t_unknown();
    host.idle(1'b0);
    host.gap(6);
    host.sel(1'b0);
    host.gap(6);
    host.shift(32'h00000055, 8);
    host.gap(8);
    chk("oe unknown", 1'b0, sdo_oe);
    host.sel(1'b1);
    host.gap(10);
  endtask
  task automatic t_buffer();
    bwrite(1'b0, 9'h1ff, 8'ha5);
    bwrite(1'b0, 9'h000, 8'h3c);
    bwrite(1'b1, 9'h1ff, 8'h5a);
    bwrite(1'b1, 9'h000, 8'hc3);
    xfer(1'b1, OP_BUF1_READ, 24, 24'hffffff, 16);
    chk("buf0 wrap", 16'ha53c, got);
    xfer(1'b0, OP_BUF2_READ, 24, 24'h0001ff, 16);
    chk("buf1 wrap", 16'h5ac3, got);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    por_n = 1'b0;
    buf_we = 1'b0;
    buf_sel = 1'b0;
    buf_waddr = 9'h000;
    buf_wdata = 8'h00;
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    host.gap(2);
    chk("oe reset", 1'b0, sdo_oe);
    chk("state reset", SFPS_POR, pwr_state);
    t_por_ignore();
    t_power_waits();
    t_status();
    t_unknown();
    t_buffer();
    end_of_test();
  end
endmodule
